/* File: pkg/arq_engine_consts.vh */
// constants shared by the transport, trace and playback logic
// assumes: included by bare name from src/ files, no other global defines of these names
`ifndef ARQ_ENGINE_CONSTS_VH
`define ARQ_ENGINE_CONSTS_VH

// transport header, word 0 and word 1
`define HDR_ACK_MSB 31
`define HDR_ACK_LSB 0
`define HDR_SEQ_MSB 63
`define HDR_SEQ_LSB 32
`define HDR_VALID_MSB 31
`define HDR_VALID_LSB 0
`define HDR_TYPE_MSB 47
`define HDR_TYPE_LSB 32
`define HDR_CNT_MSB 63
`define HDR_CNT_LSB 48

// payload type codes
`define TYPE_TRACE 16'h0ca5
`define TYPE_PLAYBACK 16'h0c5a
`define TYPE_FPGA_CFG 16'h0c1b
`define TYPE_CHIP_CFG 16'h2a1b

// payload size
`define PAYLOAD_MAX_BYTES 1456
`define ENTRY_BYTES 8
`define MAX_ENTRIES 16'h00b6

// configuration payload flag positions
`define CFG_CLR_PLAYBACK 0
`define CFG_CLR_TRACE 1
`define CFG_EXP_START 2
`define CFG_TRACE_START 3
`define CFG_TRACE_STOP 4
`define CFG_READ_PULSES 5
`define CFG_READ_CFGS 6
`define CFG_FLAG_W 7

// trace slot layout, two 32-bit slots per 64-bit entry
`define SLOT_OVF_BIT 31
`define EMPTY_SLOT 32'h40000000

// playback entry layout
`define GRP_TIME_MSB 13
`define GRP_TIME_LSB 0
`define GRP_PULSE_MSB 27
`define GRP_PULSE_LSB 14
`define GRP_CFG_MSB 41
`define GRP_CFG_LSB 28
`define CMD_BIT 48
`define CMD_SEL_BIT 15
`define CMD_OVF_MSB 45
`define CMD_OVF_LSB 16
`define PB_TS_MSB 14
`define PB_LBL_MSB 26
`define PB_LBL_LSB 15
`define PB_DEST_MSB 61
`define PB_DEST_LSB 59
`define PB_DATA_MSB 48

// register offsets
`define REG_TIMEOUT 8'h00
`define REG_STATUS 8'h04
`define REG_RX_SEQ 8'h08
`define REG_TX_BASE 8'h0c

`endif

/* File: src/dp_ram.v */
// simple dual-port memory, one write port and one registered read port
// assumes: single clock; read data valid the cycle after the read enable
`timescale 1ns/1ps
module dp_ram #(
  parameter W = 64,
  parameter AW = 12
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  // read port
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= {W{1'b0}};
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // dp_ram

/* File: src/arq_trace_playback_engine.v */
// go-back-n transport endpoint with trace readout and playback release
// assumes: rx/tx carry udp payload as 64-bit words, headers first; sys_time and ts_overflow
// come from the device time base; all inputs synchronous to sys_clk
`timescale 1ns/1ps
`include "arq_engine_consts.vh"
module arq_trace_playback_engine #(
  parameter WINDOW = 512,
  parameter TIMEOUT_DEFAULT = 40000,
  parameter PB_AW = 12,
  parameter TR_AW = 12
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // frames from host
  input wire rx_valid,
  input wire [63:0] rx_data,
  input wire rx_last,
  output wire rx_ready,
  // frames to host
  output reg tx_valid,
  output reg [63:0] tx_data,
  output reg tx_last,
  input wire tx_ready,
  // time base
  input wire [13:0] sys_time,
  input wire ts_overflow,
  // pulses to trace
  input wire pulse_valid,
  input wire [14:0] pulse_ts,
  input wire [2:0] pulse_chip,
  input wire [8:0] pulse_neuron,
  // playback toward chips
  output reg pb_pulse_valid,
  output reg [14:0] pb_pulse_ts,
  output reg [11:0] pb_pulse_label,
  output reg pb_cfg_valid,
  output reg [2:0] pb_cfg_chip,
  output reg [48:0] pb_cfg_data,
  // raw chip configuration forward
  output reg chip_cfg_valid,
  output reg [63:0] chip_cfg_data,
  // held control flags
  output wire experiment_start_flag,
  output wire read_traced_pulses_flag
);
  localparam RX_H0 = 2'd0, RX_H1 = 2'd1, RX_PAY = 2'd2, RX_SKIP = 2'd3;
  localparam T_IDLE = 3'd0, T_H1 = 3'd1, T_RD = 3'd2, T_LD = 3'd3;
  localparam P_IDLE = 3'd0, P_FETCH = 3'd1, P_HDR = 3'd2, P_TIME = 3'd3;
  localparam P_NEXT = 3'd4, P_EMIT = 3'd5, P_WOVF = 3'd6;
  localparam [31:0] WIN = WINDOW;
  localparam [31:0] MAXE = {16'h0000, `MAX_ENTRIES};

  reg [31:0] timeout_q;
  reg [1:0] rx_st_q;
  reg rx_ok_q;
  reg [31:0] exp_seq_q;
  reg [15:0] rx_type_q;
  reg [15:0] rx_left_q;
  reg ack_pend_q;
  reg [`CFG_FLAG_W-1:0] flags_q;
  reg [2:0] tx_st_q;
  reg [31:0] nxt_seq_q, base_seq_q, first_seq_q, timer_q;
  reg rd_active_q, cur_data_q;
  reg [TR_AW:0] end_q;
  reg [TR_AW-1:0] cur_addr_q;
  reg [15:0] cur_n_q;
  reg trace_run_q, pend_q;
  reg [31:0] pend_slot_q;
  reg [TR_AW:0] tw_q;
  reg [30:0] ovf_cnt_q;
  reg [2:0] pb_st_q;
  reg [PB_AW-1:0] pb_wa_q, pb_ra_q;
  reg [13:0] grp_time_q, p_left_q, c_left_q;
  reg [29:0] wait_n_q, wait_cnt_q;

  assign rx_ready = 1'b1;
  assign experiment_start_flag = flags_q[`CFG_EXP_START];
  assign read_traced_pulses_flag = flags_q[`CFG_READ_PULSES];

  // receive decode
  wire rx_h0 = rx_valid && (rx_st_q == RX_H0);
  wire rx_h1 = rx_valid && (rx_st_q == RX_H1);
  wire rx_pay = rx_valid && (rx_st_q == RX_PAY) && (rx_left_q != 16'h0000);
  wire [31:0] rx_ack = rx_data[`HDR_ACK_MSB:`HDR_ACK_LSB];
  wire [31:0] rx_seq = rx_data[`HDR_SEQ_MSB:`HDR_SEQ_LSB];
  wire rx_has_valid = rx_data[`HDR_VALID_MSB:`HDR_VALID_LSB] != 32'h0;
  wire [15:0] rx_cnt = rx_data[`HDR_CNT_MSB:`HDR_CNT_LSB];
  wire rx_dispatch = rx_ok_q && rx_has_valid && (rx_cnt != 16'h0000);
  wire [31:0] out_span = nxt_seq_q - base_seq_q;
  wire [31:0] ack_span = rx_ack - base_seq_q;
  wire ack_take = rx_h0 && (ack_span < out_span);
  wire cfg_wr = rx_pay && (rx_type_q == `TYPE_FPGA_CFG);
  wire start_pulse = cfg_wr && rx_data[`CFG_EXP_START];
  wire readout_req = cfg_wr && rx_data[`CFG_READ_PULSES] && !rd_active_q;
  wire clr_pb = cfg_wr && rx_data[`CFG_CLR_PLAYBACK];
  wire clr_tr = cfg_wr && rx_data[`CFG_CLR_TRACE];
  wire pb_we = rx_pay && (rx_type_q == `TYPE_PLAYBACK) && !(&pb_wa_q);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= RX_H0;
      rx_ok_q <= 1'b0;
      exp_seq_q <= 32'h00000000;
      rx_type_q <= 16'h0000;
      rx_left_q <= 16'h0000;
      flags_q <= {`CFG_FLAG_W{1'b0}};
      chip_cfg_valid <= 1'b0;
      chip_cfg_data <= 64'h0;
    end else begin
      chip_cfg_valid <= 1'b0;
      if (rx_valid) begin
        case (rx_st_q)
          RX_H0: begin
            rx_ok_q <= (rx_seq == exp_seq_q);
            rx_st_q <= rx_last ? RX_H0 : RX_H1;
          end
          RX_H1: begin
            if (rx_ok_q && rx_has_valid) begin
              exp_seq_q <= exp_seq_q + 32'h1;
            end
            rx_type_q <= rx_data[`HDR_TYPE_MSB:`HDR_TYPE_LSB];
            rx_left_q <= (rx_cnt > `MAX_ENTRIES) ? `MAX_ENTRIES : rx_cnt;
            if (rx_last) begin
              rx_st_q <= RX_H0;
            end else begin
              rx_st_q <= rx_dispatch ? RX_PAY : RX_SKIP;
            end
          end
          RX_PAY: begin
            if (rx_left_q != 16'h0000) begin
              rx_left_q <= rx_left_q - 16'h1;
            end
            // dispatch by type; trace and unknown codes are dropped here
            if (cfg_wr) begin
              flags_q <= rx_data[`CFG_FLAG_W-1:0];
            end
            if (rx_pay && (rx_type_q == `TYPE_CHIP_CFG)) begin
              chip_cfg_valid <= 1'b1;
              chip_cfg_data <= rx_data;
            end
            if (rx_last) begin
              rx_st_q <= RX_H0;
            end
          end
          default: begin
            if (rx_last) begin
              rx_st_q <= RX_H0;
            end
          end
        endcase
      end
    end
  end

  // trace capture: pulses pair into slots, an overflow slot closes the current entry
  wire [31:0] pulse_slot = {2'b00, 3'b000, pulse_chip, pulse_neuron, pulse_ts};
  wire [30:0] ovf_cnt_d = ovf_cnt_q + 31'h1;
  wire [31:0] ovf_slot = {1'b1, ovf_cnt_d};
  wire tr_room = !tw_q[TR_AW];
  wire flush = readout_req && pend_q;
  wire cap_ovf = trace_run_q && ts_overflow && !flush;
  wire cap_pulse = trace_run_q && pulse_valid && !flush;
  reg tr_we;
  reg [63:0] tr_wdata;
  always @* begin
    tr_we = 1'b0;
    tr_wdata = 64'h0;
    if (flush) begin
      tr_we = tr_room;
      tr_wdata = {`EMPTY_SLOT, pend_slot_q};
    end else if (cap_ovf) begin
      tr_we = tr_room;
      tr_wdata = pend_q ? {ovf_slot, pend_slot_q} : {`EMPTY_SLOT, ovf_slot};
    end else if (cap_pulse && pend_q) begin
      tr_we = tr_room;
      tr_wdata = {pulse_slot, pend_slot_q};
    end
  end
  wire [TR_AW:0] tw_d = tr_we ? tw_q + {{TR_AW{1'b0}}, 1'b1} : tw_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trace_run_q <= 1'b0;
      pend_q <= 1'b0;
      pend_slot_q <= 32'h0;
      tw_q <= {(TR_AW+1){1'b0}};
      ovf_cnt_q <= 31'h0;
    end else begin
      if (cfg_wr) begin
        trace_run_q <= rx_data[`CFG_TRACE_START] |
                       (trace_run_q & ~rx_data[`CFG_TRACE_STOP]);
      end
      if (start_pulse) begin
        ovf_cnt_q <= 31'h0;
      end else if (ts_overflow) begin
        ovf_cnt_q <= ovf_cnt_d;
      end
      if (clr_tr) begin
        tw_q <= {(TR_AW+1){1'b0}};
        pend_q <= 1'b0;
      end else begin
        tw_q <= tw_d;
        if (flush) begin
          pend_q <= 1'b0;
        end else if (cap_ovf || (cap_pulse && pend_q)) begin
          pend_q <= cap_ovf && cap_pulse;
          pend_slot_q <= pulse_slot;
        end else if (cap_pulse) begin
          pend_q <= 1'b1;
          pend_slot_q <= pulse_slot;
        end
      end
    end
  end

  // transmit: frame n of a readout starts at entry n times the frame size
  wire [31:0] frame_ofs = nxt_seq_q - first_seq_q;
  wire [63:0] frame_prod = frame_ofs * MAXE;
  wire [31:0] frame_addr = frame_prod[31:0];
  wire [31:0] end_w = {{(31-TR_AW){1'b0}}, end_q};
  wire [31:0] remain = end_w - frame_addr;
  wire have_data = rd_active_q && (frame_addr < end_w);
  wire win_ok = out_span < WIN;
  wire tx_free = !tx_valid || tx_ready;
  wire [31:0] ack_out = exp_seq_q - 32'h1;
  wire tr_re = (tx_st_q == T_RD) && tx_free;
  wire [63:0] tr_rdata;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q <= T_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 64'h0;
      tx_last <= 1'b0;
      nxt_seq_q <= 32'h0;
      base_seq_q <= 32'h0;
      first_seq_q <= 32'h0;
      timer_q <= 32'h0;
      rd_active_q <= 1'b0;
      cur_data_q <= 1'b0;
      end_q <= {(TR_AW+1){1'b0}};
      cur_addr_q <= {TR_AW{1'b0}};
      cur_n_q <= 16'h0;
      ack_pend_q <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (readout_req) begin
        rd_active_q <= 1'b1;
        first_seq_q <= nxt_seq_q;
        end_q <= tw_d;
      end else if (rd_active_q && !have_data && (out_span == 32'h0)) begin
        rd_active_q <= 1'b0;
      end
      if (ack_take) begin
        base_seq_q <= rx_ack + 32'h1;
      end
      case (tx_st_q)
        T_IDLE: begin
          if (tx_free && ((have_data && win_ok) || ack_pend_q)) begin
            cur_data_q <= have_data && win_ok;
            cur_addr_q <= frame_addr[TR_AW-1:0];
            cur_n_q <= (remain > MAXE) ? `MAX_ENTRIES : remain[15:0];
            tx_data <= {nxt_seq_q, ack_out};
            tx_valid <= 1'b1;
            tx_last <= 1'b0;
            tx_st_q <= T_H1;
          end
        end
        T_H1: begin
          if (tx_free) begin
            tx_data <= cur_data_q ? {cur_n_q, `TYPE_TRACE, 32'h00000001} : 64'h0;
            tx_valid <= 1'b1;
            tx_last <= !cur_data_q;
            tx_st_q <= cur_data_q ? T_RD : T_IDLE;
          end
        end
        T_RD: begin
          if (tx_free) begin
            tx_st_q <= T_LD;
          end
        end
        T_LD: begin
          tx_data <= tr_rdata;
          tx_valid <= 1'b1;
          tx_last <= (cur_n_q == 16'h1);
          cur_n_q <= cur_n_q - 16'h1;
          cur_addr_q <= cur_addr_q + {{(TR_AW-1){1'b0}}, 1'b1};
          tx_st_q <= (cur_n_q == 16'h1) ? T_IDLE : T_RD;
        end
        default: tx_st_q <= T_IDLE;
      endcase
      // sequence advance, rewind on timeout has priority
      if (ack_take || (out_span == 32'h0)) begin
        timer_q <= 32'h0;
      end else if (timer_q >= timeout_q) begin
        timer_q <= 32'h0;
      end else begin
        timer_q <= timer_q + 32'h1;
      end
      if (!ack_take && (out_span != 32'h0) && (timer_q >= timeout_q)) begin
        nxt_seq_q <= base_seq_q;
      end else if ((tx_st_q == T_IDLE) && tx_free && have_data && win_ok) begin
        nxt_seq_q <= nxt_seq_q + 32'h1;
      end
      // a new frame with valid bits, in sequence or not, in the same cycle keeps the acknowledge pending
      if (rx_h1 && rx_has_valid) begin
        ack_pend_q <= 1'b1;
      end else if ((tx_st_q == T_IDLE) && tx_free && ((have_data && win_ok) || ack_pend_q)) begin
        ack_pend_q <= 1'b0;
      end
    end
  end

  // playback release
  wire [63:0] pb_rdata;
  wire pb_empty = (pb_ra_q == pb_wa_q);
  wire pb_end = (pb_st_q == P_FETCH) && pb_empty && !pb_we;
  wire pb_re = ((pb_st_q == P_FETCH) || (pb_st_q == P_NEXT)) && !pb_empty &&
               !((pb_st_q == P_NEXT) && (p_left_q == 14'h0) && (c_left_q == 14'h0));

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pb_st_q <= P_IDLE;
      pb_wa_q <= {PB_AW{1'b0}};
      pb_ra_q <= {PB_AW{1'b0}};
      grp_time_q <= 14'h0;
      p_left_q <= 14'h0;
      c_left_q <= 14'h0;
      wait_n_q <= 30'h0;
      wait_cnt_q <= 30'h0;
      pb_pulse_valid <= 1'b0;
      pb_pulse_ts <= 15'h0;
      pb_pulse_label <= 12'h0;
      pb_cfg_valid <= 1'b0;
      pb_cfg_chip <= 3'h0;
      pb_cfg_data <= 49'h0;
    end else begin
      pb_pulse_valid <= 1'b0;
      pb_cfg_valid <= 1'b0;
      if (clr_pb || pb_end) begin
        pb_wa_q <= {PB_AW{1'b0}};
      end else if (pb_we) begin
        pb_wa_q <= pb_wa_q + {{(PB_AW-1){1'b0}}, 1'b1};
      end
      if (clr_pb || pb_end) begin
        pb_ra_q <= {PB_AW{1'b0}};
      end else if (pb_re) begin
        pb_ra_q <= pb_ra_q + {{(PB_AW-1){1'b0}}, 1'b1};
      end
      if (clr_pb) begin
        pb_st_q <= P_IDLE;
      end else begin
        case (pb_st_q)
          P_IDLE: if (start_pulse) pb_st_q <= P_FETCH;
          P_FETCH: begin
            if (pb_end) begin
              pb_st_q <= P_IDLE;
            end else if (pb_re) begin
              pb_st_q <= P_HDR;
            end
          end
          P_HDR: begin
            if (pb_rdata[`CMD_BIT]) begin
              wait_n_q <= pb_rdata[`CMD_OVF_MSB:`CMD_OVF_LSB];
              wait_cnt_q <= 30'h0;
              if (pb_rdata[`CMD_SEL_BIT]) begin
                pb_st_q <= P_IDLE;
              end else if (pb_rdata[`CMD_OVF_MSB:`CMD_OVF_LSB] == 30'h0) begin
                pb_st_q <= P_FETCH;
              end else begin
                pb_st_q <= P_WOVF;
              end
            end else begin
              grp_time_q <= pb_rdata[`GRP_TIME_MSB:`GRP_TIME_LSB];
              p_left_q <= pb_rdata[`GRP_PULSE_MSB:`GRP_PULSE_LSB];
              c_left_q <= pb_rdata[`GRP_CFG_MSB:`GRP_CFG_LSB];
              pb_st_q <= P_TIME;
            end
          end
          P_TIME: if (sys_time == grp_time_q) pb_st_q <= P_NEXT;
          P_NEXT: begin
            // entries not yet written stall the group instead of ending it
            if ((p_left_q == 14'h0) && (c_left_q == 14'h0)) begin
              pb_st_q <= P_FETCH;
            end else if (pb_re) begin
              pb_st_q <= P_EMIT;
            end
          end
          P_EMIT: begin
            if (p_left_q != 14'h0) begin
              pb_pulse_valid <= 1'b1;
              pb_pulse_ts <= pb_rdata[`PB_TS_MSB:0];
              pb_pulse_label <= pb_rdata[`PB_LBL_MSB:`PB_LBL_LSB];
              p_left_q <= p_left_q - 14'h1;
            end else begin
              pb_cfg_valid <= 1'b1;
              pb_cfg_chip <= pb_rdata[`PB_DEST_MSB:`PB_DEST_LSB];
              pb_cfg_data <= pb_rdata[`PB_DATA_MSB:0];
              c_left_q <= c_left_q - 14'h1;
            end
            pb_st_q <= P_NEXT;
          end
          P_WOVF: begin
            if (ts_overflow) begin
              wait_cnt_q <= wait_cnt_q + 30'h1;
              if (wait_cnt_q + 30'h1 == wait_n_q) begin
                pb_st_q <= P_FETCH;
              end
            end
          end
          default: pb_st_q <= P_IDLE;
        endcase
      end
    end
  end

  dp_ram #(.W(64), .AW(PB_AW)) u_pb_mem (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .we(pb_we), .waddr(pb_wa_q), .wdata(rx_data),
    .re(pb_re), .raddr(pb_ra_q), .rdata(pb_rdata)
  );

  dp_ram #(.W(64), .AW(TR_AW)) u_tr_mem (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .we(tr_we), .waddr(tw_q[TR_AW-1:0]), .wdata(tr_wdata),
    .re(tr_re), .raddr(cur_addr_q), .rdata(tr_rdata)
  );

  // register port
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_q <= TIMEOUT_DEFAULT;
      reg_rdata <= 32'h0;
    end else begin
      if (reg_wr && (reg_addr == `REG_TIMEOUT)) begin
        timeout_q <= reg_wdata;
      end
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `REG_TIMEOUT: reg_rdata <= timeout_q;
          `REG_STATUS: reg_rdata <= {21'h0, ack_pend_q, trace_run_q, rd_active_q,
                                    pb_st_q, tx_st_q, rx_st_q};
          `REG_RX_SEQ: reg_rdata <= exp_seq_q;
          `REG_TX_BASE: reg_rdata <= base_seq_q;
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // arq_trace_playback_engine

/* File: verif/host_link_model.sv */
// host side of the frame link: takes tx words and keeps the first word of the last frame
// assumes: the engine holds each tx word until it is accepted
`timescale 1ns/1ps
module host_link_model (
  // clock
  input wire sys_clk,
  // frames to host
  input wire tx_valid,
  input wire [63:0] tx_data,
  input wire tx_last,
  output reg tx_ready
);
  integer seed = 1;
  reg first_q = 1'b1;
  reg [63:0] last_hdr0 = 64'h0;
  initial tx_ready = 1'b0;
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      if (first_q) last_hdr0 <= tx_data;
      first_q <= tx_last;
    end
    // stalls at random, so slow and prompt acceptance both occur
    tx_ready <= ($random(seed) % 2) == 0;
  end
endmodule // host_link_model

/* File: verif/arq_engine_assertions.sv */
// port checker for the transport and playback engine
// assumes: bound to the engine top, one clock, reset active low
`timescale 1ns/1ps
module arq_engine_checker (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // watched ports
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire rx_valid,
  input wire [63:0] rx_data,
  input wire rx_ready,
  input wire tx_valid,
  input wire [63:0] tx_data,
  input wire tx_last,
  input wire tx_ready,
  input wire pb_pulse_valid,
  input wire pb_cfg_valid,
  input wire chip_cfg_valid,
  input wire [63:0] chip_cfg_data,
  input wire experiment_start_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_rdata_after_read: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its slot");
  a_rx_always_taken: assert property (rx_ready)
    else $error("receive side stalled");
  a_tx_word_holds: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx word dropped");
  a_chip_cfg_copy: assert property (chip_cfg_valid |->
    $past(rx_valid) && chip_cfg_data == $past(rx_data)) else $error("chip config not copied");
  a_pulse_spaced: assert property (pb_pulse_valid |=> !pb_pulse_valid && !pb_cfg_valid)
    else $error("pulse output too close");
  a_cfg_spaced: assert property (pb_cfg_valid |=> !pb_cfg_valid && !pb_pulse_valid)
    else $error("config output too close");
  a_start_flag_cause: assert property ($changed(experiment_start_flag) |-> $past(rx_valid))
    else $error("start flag moved without a frame");
  a_play_no_pair: assert property (!(pb_pulse_valid && pb_cfg_valid))
    else $error("pulse and config together");
  c_tx_stall: cover property (tx_valid && !tx_ready);
  c_pulse_out: cover property (pb_pulse_valid);
  c_chip_cfg: cover property (chip_cfg_valid);
endmodule // arq_engine_checker
bind arq_trace_playback_engine arq_engine_checker i_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .pb_pulse_valid(pb_pulse_valid), .pb_cfg_valid(pb_cfg_valid),
  .chip_cfg_valid(chip_cfg_valid), .chip_cfg_data(chip_cfg_data),
  .experiment_start_flag(experiment_start_flag));

/* File: verif/test_arq_trace_playback_engine.sv */
// self-checking bench: host frames in, playback and chip config out
// assumes: short timeout parameter, small memories
`timescale 1ns/1ps
`include "arq_engine_consts.vh"
module test_arq_trace_playback_engine;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] reg_addr = 8'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg rx_valid = 1'b0;
  reg rx_last = 1'b0;
  reg [63:0] rx_data = 64'h0;
  reg [13:0] sys_time = 14'h0;
  reg ts_overflow = 1'b0;
  reg pulse_valid = 1'b0;
  reg [14:0] pulse_ts = 15'h0;
  reg [2:0] pulse_chip = 3'h0;
  reg [8:0] pulse_neuron = 9'h0;
  wire [31:0] reg_rdata;
  wire rx_ready, tx_valid, tx_last, tx_ready, pb_pulse_valid, pb_cfg_valid, chip_cfg_valid;
  wire [63:0] tx_data, chip_cfg_data;
  wire [14:0] pb_pulse_ts;
  wire [11:0] pb_pulse_label;
  wire [2:0] pb_cfg_chip;
  wire [48:0] pb_cfg_data;
  wire start_flag, read_flag;
  integer errors = 0, samples_checked = 0, seed = 1, i;
  reg [63:0] ent_q[$], chip_q[$], out_q[$], w, g2[$];
  arq_trace_playback_engine #(.TIMEOUT_DEFAULT(50), .PB_AW(4), .TR_AW(4)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .sys_time(sys_time),
    .ts_overflow(ts_overflow), .pulse_valid(pulse_valid), .pulse_ts(pulse_ts),
    .pulse_chip(pulse_chip), .pulse_neuron(pulse_neuron),
    .pb_pulse_valid(pb_pulse_valid), .pb_pulse_ts(pb_pulse_ts),
    .pb_pulse_label(pb_pulse_label), .pb_cfg_valid(pb_cfg_valid), .pb_cfg_chip(pb_cfg_chip),
    .pb_cfg_data(pb_cfg_data), .chip_cfg_valid(chip_cfg_valid), .chip_cfg_data(chip_cfg_data),
    .experiment_start_flag(start_flag), .read_traced_pulses_flag(read_flag));
  host_link_model i_host (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) sys_time <= sys_time + 14'h1;
  // random overflows and pulses; capture only listens while trace is started
  always @(posedge sys_clk) begin
    ts_overflow <= ($random(seed) % 8) == 0;
    pulse_valid <= 1'($random(seed));
    {pulse_chip, pulse_neuron, pulse_ts} <= 27'($random(seed));
  end
  task automatic check(input [63:0] got, input [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // every output pops the model queue; an unexpected one meets an empty queue
  always @(posedge sys_clk) begin
    if (chip_cfg_valid) check(chip_cfg_data, chip_q.pop_front());
    if (pb_pulse_valid) check({37'h0, pb_pulse_label, pb_pulse_ts}, out_q.pop_front());
    if (pb_cfg_valid) check({1'b1, 11'h0, pb_cfg_chip, pb_cfg_data}, out_q.pop_front());
  end
  task reg_write(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task reg_read(input [7:0] a, input [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check({32'h0, reg_rdata}, {32'h0, e});
    @(posedge sys_clk);
  endtask
  // header words first, then the entries queued in ent_q
  task send(input [31:0] seq, input [31:0] vld, input [15:0] typ);
    rx_valid <= 1'b1;
    rx_last <= 1'b0;
    rx_data <= {seq, 32'hffffffff};
    @(posedge sys_clk);
    rx_data <= {16'(ent_q.size()), typ, vld};
    rx_last <= ent_q.size() == 0;
    @(posedge sys_clk);
    while (ent_q.size() > 0) begin
      rx_data <= ent_q.pop_front();
      rx_last <= ent_q.size() == 0;
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    @(posedge sys_clk);
  endtask
  task drain;
    for (i = 0; i < 500 && out_q.size() > 0; i++) @(posedge sys_clk);
    if (out_q.size() > 0) begin
      errors++;
      $display("MISMATCH %0t playback output missing", $time);
      report_and_stop;
    end
  endtask
  // one group: header, two pulses, one config entry; expectations go to g2 or out_q
  task group(input [13:0] t, input to_g2);
    ent_q.push_back({22'h0, 14'h1, 14'h2, t});
    repeat (2) begin
      w = {37'h0, 27'($random(seed))};
      ent_q.push_back(w);
      if (to_g2) g2.push_back(w);
      else out_q.push_back(w);
    end
    // bit 48 stays low so the entry is never read as a command
    w = {$random(seed), $random(seed)} & 64'h3800_ffff_ffff_ffff;
    ent_q.push_back({2'h0, w[61:59], 10'h0, w[48:0]});
    w = {1'b1, 11'h0, w[61:59], 1'b0, w[47:0]};
    if (to_g2) g2.push_back(w);
    else out_q.push_back(w);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    reg_read(`REG_TIMEOUT, 32'd50);
    reg_read(`REG_STATUS, 32'h0);
    reg_write(`REG_TIMEOUT, 32'h1d);
    reg_read(`REG_TIMEOUT, 32'h1d);
    reg_read(8'hf0, 32'h0);
    reg_write(`REG_RX_SEQ, 32'h5);
    reg_read(`REG_RX_SEQ, 32'h0);
    for (i = 0; i < 3; i++) begin
      w = {$random(seed), $random(seed)};
      ent_q.push_back(w);
      chip_q.push_back(w);
    end
    send(0, 1, `TYPE_CHIP_CFG);
    ent_q.push_back(64'h1);
    send(7, 1, `TYPE_CHIP_CFG);
    ent_q.push_back(64'h2);
    send(1, 0, `TYPE_CHIP_CFG);
    reg_read(`REG_RX_SEQ, 32'h1);
    ent_q.push_back(64'h3);
    send(1, 1, 16'h1234);
    reg_read(`REG_RX_SEQ, 32'h2);
    group(sys_time + 14'd100, 1'b0);
    ent_q.push_back(64'h0001_0000_0000_8000);
    ent_q.push_back(64'h0001_0000_0002_0000);
    group(sys_time + 14'd320, 1'b1);
    send(2, 1, `TYPE_PLAYBACK);
    ent_q.push_back(64'h4);
    send(3, 1, `TYPE_FPGA_CFG);
    #1 check({63'h0, start_flag}, 64'h1);
    drain;
    repeat (100) @(posedge sys_clk);
    ent_q.push_back(64'h4);
    send(4, 1, `TYPE_FPGA_CFG);
    while (g2.size() > 0) out_q.push_back(g2.pop_front());
    drain;
    ent_q.push_back(64'h20);
    send(5, 1, `TYPE_FPGA_CFG);
    #1 check({62'h0, start_flag, read_flag}, 64'h1);
    repeat (60) @(posedge sys_clk);
    reg_read(`REG_TX_BASE, 32'h0);
    check({32'h0, i_host.last_hdr0[31:0]}, 64'h5);
    check({32'h0, i_host.last_hdr0[63:32]}, 64'h0);
    report_and_stop;
  end
endmodule // test_arq_trace_playback_engine
